//--- mrc_defs.vh
`ifndef MRC_DEFS_VH
`define MRC_DEFS_VH
// Register offsets (byte addresses on the register port)
`define MRC_REG_CTRL   4'h0
`define MRC_REG_PEAK   4'h4
`define MRC_REG_STAT   4'h8
// Control register field positions
`define MRC_CTRL_LOCK  0
`define MRC_CTRL_HOLD  1
`define MRC_CTRL_RLO   2
`define MRC_CTRL_RHI   3
`define MRC_CTRL_CLR   4
// Status register field positions
`define MRC_STAT_BUSY  0
`define MRC_STAT_OVF   1
`define MRC_STAT_PLO   4
`define MRC_STAT_PHI   5
// Reset values
`define MRC_RST_LOCK   1'b0
`define MRC_RST_HOLD   1'b0
`define MRC_RST_RANGE  2'h0
`define MRC_RST_MULT   8'h20
// Characters
`define MRC_CH_CR      8'h0D
`define MRC_CH_LF      8'h0A
`define MRC_CH_SP      8'h20
`define MRC_CH_ZERO    8'h30
`define MRC_CH_PLUS    8'h2B
`define MRC_CH_DOT     8'h2E
// Command names, right aligned in 48 bits
`define MRC_NM_LOCK    48'h0000_4C4F_434B
`define MRC_NM_LOCKQ   48'h004C_4F43_4B3F
`define MRC_NM_HOLD    48'h0000_004D_4158
`define MRC_NM_HOLDQ   48'h0000_4D41_583F
`define MRC_NM_CLR     48'h0000_4D41_5843
`define MRC_NM_VALQ    48'h004D_4158_523F
`define MRC_NM_MULQ    48'h4D41_5852_4D3F
`define MRC_NM_RANGE   48'h0052_414E_4745
`define MRC_NM_RANGEQ  48'h5241_4E47_453F
// Reply kinds
`define MRC_RK_DIGIT   2'h0
`define MRC_RK_VALUE   2'h1
`define MRC_RK_MULT    2'h2
`endif

//--- mrc_line_buf.v
`timescale 1ns/1ps
// Small line memory holding one received command line
module mrc_line_buf #(
  parameter DW = 8,                 // Character width
  parameter AW = 4                  // Address width
) (
  input  wire          core_clk_i,  // Core clock
  input  wire          wr_en_i,     // Write enable
  input  wire [AW-1:0] wr_addr_i,   // Write address
  input  wire [DW-1:0] wr_data_i,   // Write character
  input  wire [AW-1:0] rd_addr_i,   // Read address
  output reg  [DW-1:0] rd_data_o    // Registered read character
);
  reg [DW-1:0] mem [0:(1<<AW)-1];   // Storage, no reset needed

  // Write port and registered read port
  always @(posedge core_clk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= mem[rd_addr_i];
  end
endmodule // mrc_line_buf

//--- mrc_cmd.v
`timescale 1ns/1ps
`include "mrc_defs.vh"
// Summary of operation
// RQ1 - Lock ignores keys except alarm key
// RQ2 - Lock query returns one digit, terminator
// RQ3 - Peak hold on/off by digit, queryable
// RQ4 - Peak clear zeroes, then captures again
// RQ5 - Peak query: plus, digits, ranged point
// RQ6 - Multiplier query returns one character
// RQ7 - Range code 0 highest to 3 lowest
// RQ8 - Four ranges, span set by probe
// RQ9 - Act only after complete terminated line
module mrc_cmd #(
  parameter AW = 4                       // Line buffer address width
) (
  input  wire        core_clk_i,         // Core clock, 125 MHz
  input  wire        nrst_i,             // Async reset, active low
  input  wire [7:0]  rx_data_i,          // Received character
  input  wire        rx_valid_i,         // Received character valid
  output wire        rx_ready_o,         // Ready for a character
  output reg  [7:0]  tx_data_o,          // Reply character
  output wire        tx_valid_o,         // Reply character valid
  input  wire        tx_ready_i,         // Host link takes reply character
  input  wire [7:0]  key_code_i,         // Front panel key code
  input  wire        key_valid_i,        // Front panel key press
  input  wire        key_alarm_i,        // Pressed key is the alarm key
  output reg  [7:0]  key_code_o,         // Key code passed to panel logic
  output reg         key_valid_o,        // Key press passed to panel logic
  input  wire [19:0] meas_bcd_i,         // Reading magnitude, five BCD digits
  input  wire [2:0]  meas_dp_i,          // Digits after point for range
  input  wire [7:0]  meas_mult_i,        // Multiplier character for range
  input  wire        meas_valid_i,       // New reading strobe
  input  wire [1:0]  probe_type_i,       // Attached probe type
  output reg  [3:0]  range_sel_o,        // Probe type and range code
  output reg         lock_o,             // Keypad lock state
  output reg         hold_o,             // Peak hold enable
  output reg  [19:0] peak_bcd_o,         // Held peak magnitude
  input  wire [3:0]  reg_addr_i,         // Register byte address
  input  wire [31:0] reg_wdata_i,        // Register write data
  input  wire        reg_wr_i,           // Register write strobe
  input  wire        reg_rd_i,           // Register read strobe
  output reg  [31:0] reg_rdata_o         // Register read data
);
  localparam [3:0] ST_IDLE = 4'b0001;   // Collect characters
  localparam [3:0] ST_LOAD = 4'b0010;   // Scan stored line
  localparam [3:0] ST_EXEC = 4'b0100;   // Decode and act
  localparam [3:0] ST_SEND = 4'b1000;   // Stream reply

  reg  [3:0]    state;                  // Controller state
  reg  [AW-1:0] wr_ptr;                 // Next write slot
  reg  [AW-1:0] len;                    // Stored line length
  reg           ovf;                    // Line overflowed, drop it
  reg  [AW-1:0] rd_ptr;                 // Scan address
  reg           ld_vld;                 // Read data valid this cycle
  wire [7:0]    ld_ch;                  // Character from line memory
  reg  [47:0]   name;                   // Command word, right aligned
  reg           seen_sp;                // Separator passed
  reg  [7:0]    arg;                    // Argument character
  reg  [1:0]    arg_cnt;                // Argument characters seen
  reg  [1:0]    range;                  // Selected range code
  reg  [2:0]    peak_dp;                // Point position of held peak
  reg  [7:0]    peak_mult;              // Multiplier of held peak
  reg           peak_clr;               // Peak clear request
  reg  [1:0]    rkind;                  // Reply kind
  reg  [7:0]    rdigit;                 // Single character reply
  reg  [3:0]    ridx;                   // Reply character index
  reg           ovf_seen;               // Sticky overflow, for status
  wire          is_term;                // Incoming terminator
  wire          arg_ok;                 // Exactly one argument character
  wire [3:0]    blen;                   // Reply body length
  wire          tx_fire;                // Reply character taken

  assign rx_ready_o = state[0];
  assign tx_valid_o = state[3];
  assign tx_fire    = tx_valid_o & tx_ready_i;
  assign is_term    = (rx_data_i == `MRC_CH_LF);
  assign arg_ok     = seen_sp & (arg_cnt == 2'd1);
  assign blen       = (rkind == `MRC_RK_VALUE) ? ((peak_dp == 3'd0) ? 4'd6 : 4'd7) : 4'd1;

  // One BCD digit as an ASCII character
  function [7:0] bcd_ch;
    input [3:0] d;
    begin
      bcd_ch = `MRC_CH_ZERO + {4'h0, d};
    end
  endfunction

  // Reply character at a given index, terminator appended after body
  function [7:0] reply_ch;
    input [3:0]  idx;
    input [1:0]  kind;
    input [3:0]  bl;
    input [7:0]  dig;
    input [19:0] val;
    input [2:0]  dp;
    input [7:0]  mul;
    reg   [2:0]  nint;
    reg   [2:0]  p;
    reg   [2:0]  j;
    begin
      nint = 3'd5 - dp;
      p    = idx[2:0] - 3'd1;
      j    = (dp != 3'd0 && p > nint) ? p - 3'd1 : p;
      if (idx == bl) begin
        reply_ch = `MRC_CH_CR;
      end else if (idx > bl) begin
        reply_ch = `MRC_CH_LF;
      end else if (kind == `MRC_RK_DIGIT) begin
        reply_ch = dig;
      end else if (kind == `MRC_RK_MULT) begin
        reply_ch = mul;                                          // see RQ6
      end else if (idx == 4'd0) begin
        reply_ch = `MRC_CH_PLUS;                                 // see RQ5
      end else if (dp != 3'd0 && p == nint) begin
        reply_ch = `MRC_CH_DOT;                                  // see RQ5
      end else begin
        case (j)
          3'd0:    reply_ch = bcd_ch(val[19:16]);
          3'd1:    reply_ch = bcd_ch(val[15:12]);
          3'd2:    reply_ch = bcd_ch(val[11:8]);
          3'd3:    reply_ch = bcd_ch(val[7:4]);
          default: reply_ch = bcd_ch(val[3:0]);
        endcase
      end
    end
  endfunction

  // Line memory; the whole line is kept until its terminator arrives
  mrc_line_buf #(
    .DW (8),
    .AW (AW)
  ) u_line (
    .core_clk_i (core_clk_i),
    .wr_en_i    (state[0] & rx_valid_i & ~is_term),
    .wr_addr_i  (wr_ptr),
    .wr_data_i  (rx_data_i),
    .rd_addr_i  (rd_ptr),
    .rd_data_o  (ld_ch)
  );

  // Command controller: collect, scan, decode, reply
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state    <= ST_IDLE;
      wr_ptr   <= {AW{1'b0}};
      len      <= {AW{1'b0}};
      ovf      <= 1'b0;
      ovf_seen <= 1'b0;
      rd_ptr   <= {AW{1'b0}};
      ld_vld   <= 1'b0;
      name     <= 48'h0000_0000_0000;
      seen_sp  <= 1'b0;
      arg      <= 8'h00;
      arg_cnt  <= 2'h0;
      lock_o   <= `MRC_RST_LOCK;
      hold_o   <= `MRC_RST_HOLD;
      range    <= `MRC_RST_RANGE;
      peak_clr <= 1'b0;
      rkind    <= `MRC_RK_DIGIT;
      rdigit   <= 8'h00;
      ridx     <= 4'h0;
      tx_data_o <= 8'h00;
    end else begin
      peak_clr <= 1'b0;
      // Software control write; a remote command in the same cycle wins
      if (reg_wr_i && reg_addr_i == `MRC_REG_CTRL) begin
        lock_o   <= reg_wdata_i[`MRC_CTRL_LOCK];
        hold_o   <= reg_wdata_i[`MRC_CTRL_HOLD];
        range    <= reg_wdata_i[`MRC_CTRL_RHI:`MRC_CTRL_RLO];
        peak_clr <= reg_wdata_i[`MRC_CTRL_CLR];
      end
      case (state)
        ST_IDLE: begin
          if (rx_valid_i) begin
            if (is_term) begin
              // Nothing is acted on before the terminator
              len     <= wr_ptr;                                 // see RQ9
              ovf     <= 1'b0;
              wr_ptr  <= {AW{1'b0}};
              rd_ptr  <= {AW{1'b0}};
              ld_vld  <= 1'b0;
              name    <= 48'h0000_0000_0000;
              seen_sp <= 1'b0;
              arg_cnt <= 2'h0;
              state   <= ovf ? ST_IDLE : ST_LOAD;                // see RQ9
            end else if (rx_data_i == `MRC_CH_CR) begin
              wr_ptr <= wr_ptr;                                  // Carriage return dropped
            end else if (wr_ptr == {AW{1'b1}}) begin
              ovf      <= 1'b1;                                  // Too long, whole line discarded
              ovf_seen <= 1'b1;
            end else begin
              wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
            end
          end
        end
        ST_LOAD: begin
          // Read address leads data by one cycle
          ld_vld <= (rd_ptr != len);
          if (rd_ptr != len) begin
            rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
          end
          if (ld_vld) begin
            if (ld_ch == `MRC_CH_SP) begin
              seen_sp <= 1'b1;
            end else if (!seen_sp) begin
              name <= {name[39:0], ld_ch};
            end else begin
              arg     <= ld_ch;
              arg_cnt <= (arg_cnt == 2'h3) ? arg_cnt : arg_cnt + 2'h1;
            end
          end
          if (rd_ptr == len && !ld_vld) begin
            state <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          state <= ST_IDLE;
          ridx  <= 4'h0;
          case (name)
            `MRC_NM_LOCK: begin
              if (arg_ok && (arg == "0" || arg == "1")) begin
                lock_o <= arg[0];                                // see RQ1
              end
            end
            `MRC_NM_HOLD: begin
              if (arg_ok && (arg == "0" || arg == "1")) begin
                hold_o <= arg[0];                                // see RQ3
              end
            end
            `MRC_NM_CLR: begin
              peak_clr <= ~seen_sp;                              // see RQ4
            end
            `MRC_NM_RANGE: begin
              if (arg_ok && arg >= "0" && arg <= "3") begin
                range <= arg[1:0];                               // see RQ7
              end
            end
            `MRC_NM_LOCKQ: begin
              rkind     <= `MRC_RK_DIGIT;
              rdigit    <= `MRC_CH_ZERO + {7'h00, lock_o};       // see RQ2
              tx_data_o <= `MRC_CH_ZERO + {7'h00, lock_o};
              state     <= ST_SEND;
            end
            `MRC_NM_HOLDQ: begin
              rkind     <= `MRC_RK_DIGIT;
              rdigit    <= `MRC_CH_ZERO + {7'h00, hold_o};       // see RQ3
              tx_data_o <= `MRC_CH_ZERO + {7'h00, hold_o};
              state     <= ST_SEND;
            end
            `MRC_NM_RANGEQ: begin
              rkind     <= `MRC_RK_DIGIT;
              rdigit    <= `MRC_CH_ZERO + {6'h00, range};        // see RQ7
              tx_data_o <= `MRC_CH_ZERO + {6'h00, range};
              state     <= ST_SEND;
            end
            `MRC_NM_VALQ: begin
              rkind     <= `MRC_RK_VALUE;
              tx_data_o <= `MRC_CH_PLUS;                         // see RQ5
              state     <= ST_SEND;
            end
            `MRC_NM_MULQ: begin
              rkind     <= `MRC_RK_MULT;
              tx_data_o <= peak_mult;                            // see RQ6
              state     <= ST_SEND;
            end
            default: begin
              state <= ST_IDLE;                                  // Unknown line ignored
            end
          endcase
        end
        ST_SEND: begin
          // Reply snapshot of the peak may move if a reading lands mid-reply
          if (tx_fire) begin
            ridx      <= ridx + 4'h1;
            tx_data_o <= reply_ch(ridx + 4'h1, rkind, blen, rdigit, peak_bcd_o, peak_dp, peak_mult);
            if (ridx == blen + 4'h1) begin
              state <= ST_IDLE;                                  // see RQ2
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Peak capture; BCD magnitudes order the same as binary
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      peak_bcd_o <= 20'h0_0000;
      peak_dp    <= 3'h0;
      peak_mult  <= `MRC_RST_MULT;
    end else if (peak_clr) begin
      peak_bcd_o <= 20'h0_0000;                                  // see RQ4
      peak_dp    <= meas_dp_i;
      peak_mult  <= meas_mult_i;
    end else if (hold_o && meas_valid_i && meas_bcd_i > peak_bcd_o) begin
      peak_bcd_o <= meas_bcd_i;                                  // see RQ3
      peak_dp    <= meas_dp_i;                                   // see RQ5
      peak_mult  <= meas_mult_i;                                 // see RQ6
    end
  end

  // Keypad gate; alarm key passes even when locked
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      key_code_o  <= 8'h00;
      key_valid_o <= 1'b0;
    end else begin
      key_code_o  <= key_code_i;
      key_valid_o <= key_valid_i & (~lock_o | key_alarm_i);      // see RQ1
    end
  end

  // Range output; span of each code is resolved by probe type downstream
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      range_sel_o <= 4'h0;
    end else begin
      range_sel_o <= {probe_type_i, range};                      // see RQ8
    end
  end

  // Register read port, data one cycle after the strobe
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `MRC_REG_CTRL: reg_rdata_o <= {28'h000_0000, range, hold_o, lock_o};
        `MRC_REG_PEAK: reg_rdata_o <= {1'b0, peak_dp, peak_mult, peak_bcd_o};
        `MRC_REG_STAT: reg_rdata_o <= {26'h000_0000, probe_type_i, 2'h0, ovf_seen, ~state[0]};
        default:       reg_rdata_o <= 32'h0000_0000;            // Unmapped reads zero
      endcase
    end else begin
      reg_rdata_o <= 32'h0000_0000;
    end
  end
endmodule // mrc_cmd

//--- mrc_cmd_checker.sv
`timescale 1ns/1ps
`include "mrc_defs.vh"
// Port-level checks on the command block
module mrc_cmd_checker (
  input wire        core_clk_i,   // Clock
  input wire        nrst_i,       // Reset, low
  input wire [7:0]  rx_data_i,    // Rx char
  input wire        rx_valid_i,   // Rx valid
  input wire        rx_ready_o,   // Rx ready
  input wire [7:0]  tx_data_o,    // Tx char
  input wire        tx_valid_o,   // Tx valid
  input wire        tx_ready_i,   // Tx ready
  input wire [7:0]  key_code_i,   // Key in
  input wire        key_valid_i,  // Key press
  input wire        key_alarm_i,  // Alarm key
  input wire [7:0]  key_code_o,   // Key out
  input wire        key_valid_o,  // Key out valid
  input wire        lock_o,       // Lock state
  input wire        hold_o,       // Hold state
  input wire [1:0]  probe_type_i, // Probe type
  input wire [3:0]  range_sel_o,  // Range select
  input wire [19:0] meas_bcd_i,   // Reading
  input wire        meas_valid_i, // Reading strobe
  input wire [19:0] peak_bcd_o    // Held peak
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  // Keypad gating, locked and unlocked
  chk_lock_blocks: assert property (key_valid_i && lock_o && !key_alarm_i |=> !key_valid_o)
    else $error("locked key passed");
  chk_alarm_pass: assert property (key_valid_i && key_alarm_i |=> key_valid_o && key_code_o == $past(key_code_i))
    else $error("alarm key lost");
  chk_unlock_pass: assert property (key_valid_i && !lock_o |=> key_valid_o)
    else $error("unlocked key lost");
  // Terminator taken from the host this cycle
  wire      lf_taken = rx_valid_i && rx_ready_o && rx_data_i == `MRC_CH_LF;
  // Stored characters on the open line; 16 means it overflowed and will be dropped
  reg [4:0] line_len;             // Saturates at 16
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      line_len <= 5'h00;
    end else if (rx_valid_i && rx_ready_o) begin
      if (rx_data_i == `MRC_CH_LF) begin
        line_len <= 5'h00;
      end else if (rx_data_i != `MRC_CH_CR && line_len != 5'h10) begin
        line_len <= line_len + 5'h01;
      end
    end
  end
  // Replies only once a whole line has been taken
  chk_reply_gated: assert property (rx_ready_o && !lf_taken |=> !tx_valid_o)
    else $error("reply while collecting");
  chk_line_busy: assert property (lf_taken && line_len != 5'h10 |=> !rx_ready_o)
    else $error("line end not acted on");
  chk_ovf_drop: assert property (lf_taken && line_len == 5'h10 |=> rx_ready_o && !tx_valid_o)
    else $error("overlong line acted on");
  // Range select follows the probe one cycle later; skip the edge after reset
  chk_range_probe: assert property ($past(nrst_i) |-> range_sel_o[3:2] == $past(probe_type_i))
    else $error("probe field wrong");
  // A reply character stands until taken
  chk_tx_hold: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
    else $error("reply char dropped");
  // Peak capture only with hold on
  chk_peak_grows: assert property (hold_o && meas_valid_i && meas_bcd_i > peak_bcd_o |=> peak_bcd_o == $past(meas_bcd_i))
    else $error("peak not captured");
  chk_peak_keep: assert property (meas_valid_i && !hold_o |=> $stable(peak_bcd_o))
    else $error("peak moved with hold off");
  cover property (key_valid_i && lock_o && key_alarm_i);
  cover property (tx_valid_o && !tx_ready_i);
  cover property (hold_o && meas_valid_i);
endmodule // mrc_cmd_checker

bind mrc_cmd mrc_cmd_checker chk (.*);

//--- mrc_host.sv
`timescale 1ns/1ps
`include "mrc_defs.vh"
// Remote host: streams lines, collects replies
module mrc_host (
  input  wire       clk_i,      // Clock
  output reg  [7:0] rx_data_o,  // Char to device
  output reg        rx_valid_o, // Char offered
  input  wire       rx_ready_i, // Device takes char
  input  wire [7:0] tx_data_i,  // Reply char
  input  wire       tx_valid_i, // Reply valid
  output reg        tx_ready_o  // Host takes reply
);
  reg [79:0] reply; // Last reply, right aligned
  integer    i;     // Loop index
  // Quiet link at time zero
  initial begin
    rx_data_o  = 8'h00;
    rx_valid_o = 1'b0;
    tx_ready_o = 1'b0;
  end
  // Hold one char until an edge sees ready
  task put(input [7:0] c);
    begin
      rx_data_o  <= c;
      rx_valid_o <= 1'b1;
      @(posedge clk_i);
      while (rx_ready_i !== 1'b1) @(posedge clk_i);
    end
  endtask
  // Name right aligned, optional one digit, then terminator if term is set
  task send(input [47:0] nm, input arg, input [3:0] d, input term);
    begin
      for (i = 5; i >= 0; i = i - 1)
        if (nm[i*8 +: 8] != 8'h00) put(nm[i*8 +: 8]);
      if (arg) begin
        put(`MRC_CH_SP);
        put(`MRC_CH_ZERO + d);
      end
      if (term) put(`MRC_CH_LF);
      rx_valid_o <= 1'b0;
      // Released line must not show a stale char
      rx_data_o  <= ~rx_data_o;
    end
  endtask
  // Take reply up to LF; slow mode stalls every other cycle
  task get(input slow);
    begin
      reply = 80'h0;
      for (i = 0; i < 400 && reply[7:0] !== `MRC_CH_LF; i = i + 1) begin
        tx_ready_o <= slow ? ~tx_ready_o : 1'b1;
        @(posedge clk_i);
        if (tx_valid_i && tx_ready_o) reply = {reply[71:0], tx_data_i};
      end
      tx_ready_o <= 1'b0;
    end
  endtask
endmodule // mrc_host

//--- meter_remote_command_set_bench.sv
`timescale 1ns/1ps
`include "mrc_defs.vh"
// Command block bench: remote lines, keys, readings, registers
module meter_remote_command_set_bench;
  reg         core_clk_i = 1'b0;
  reg         nrst_i = 1'b0;
  wire [7:0]  rx_data, tx_data, key_code_o;
  wire        rx_valid, rx_ready, tx_valid, tx_ready;
  wire        key_valid_o, lock_o, hold_o;
  wire [3:0]  range_sel_o;
  wire [19:0] peak_bcd_o;
  wire [31:0] reg_rdata_o;
  reg  [7:0]  key_code_i = 8'h00, meas_mult_i = 8'h00;
  reg         key_valid_i = 1'b0, key_alarm_i = 1'b0;
  reg         meas_valid_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  reg  [19:0] meas_bcd_i = 20'h0_0000;
  reg  [2:0]  meas_dp_i = 3'h0;
  reg  [1:0]  probe_type_i = 2'h2;
  reg  [3:0]  reg_addr_i = 4'h0;
  reg  [31:0] reg_wdata_i = 32'h0000_0000;
  reg  [31:0] rd;
  integer     miscompares = 0, num_checks = 0, cycles = 0, k, r;
  localparam [15:0] CRLF = {`MRC_CH_CR, `MRC_CH_LF};
  // 125 MHz clock
  always #4 core_clk_i = ~core_clk_i;
  mrc_cmd uut (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .rx_data_i(rx_data), .rx_valid_i(rx_valid),
    .rx_ready_o(rx_ready), .tx_data_o(tx_data), .tx_valid_o(tx_valid), .tx_ready_i(tx_ready),
    .key_code_i(key_code_i), .key_valid_i(key_valid_i), .key_alarm_i(key_alarm_i),
    .key_code_o(key_code_o), .key_valid_o(key_valid_o), .meas_bcd_i(meas_bcd_i), .meas_dp_i(meas_dp_i),
    .meas_mult_i(meas_mult_i), .meas_valid_i(meas_valid_i), .probe_type_i(probe_type_i),
    .range_sel_o(range_sel_o), .lock_o(lock_o), .hold_o(hold_o), .peak_bcd_o(peak_bcd_o),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o));
  mrc_host host (.clk_i(core_clk_i), .rx_data_o(rx_data), .rx_valid_o(rx_valid), .rx_ready_i(rx_ready),
    .tx_data_i(tx_data), .tx_valid_i(tx_valid), .tx_ready_o(tx_ready));
  // Verdict and end of run
  task stop_test;
    begin
      if (miscompares == 0 && num_checks > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  // One compare for every result kind
  task cmp(input [95:0] what, input [79:0] exp, input [79:0] got);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("wrong value %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  // Wait, bounded, until the block collects again
  task idle;
    begin
      @(posedge core_clk_i);
      for (k = 0; k < 200 && rx_ready !== 1'b1; k = k + 1) @(posedge core_clk_i);
      @(posedge core_clk_i);
    end
  endtask
  task cmd(input [47:0] nm, input arg, input [3:0] d);
    begin
      host.send(nm, arg, d, 1'b1);
      idle;
    end
  endtask
  task query(input [47:0] nm, input slow);
    begin
      host.send(nm, 1'b0, 4'h0, 1'b1);
      host.get(slow);
    end
  endtask
  // Register port: one-cycle strobes, read data the cycle after
  task reg_write(input [3:0] a, input [31:0] d);
    begin
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge core_clk_i);
      reg_wr_i <= 1'b0;
      @(posedge core_clk_i);
    end
  endtask
  task reg_read(input [3:0] a);
    begin
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge core_clk_i);
      reg_rd_i <= 1'b0;
      @(posedge core_clk_i);
      rd = reg_rdata_o;
    end
  endtask
  // Key press and check of what reaches the panel
  task key(input [7:0] c, input alarm, input expv);
    begin
      key_code_i <= c;
      key_alarm_i <= alarm;
      key_valid_i <= 1'b1;
      @(posedge core_clk_i);
      key_valid_i <= 1'b0;
      @(posedge core_clk_i);
      cmp("key valid", expv, key_valid_o);
      if (expv) cmp("key code", c, key_code_o);
    end
  endtask
  task meas(input [19:0] v);
    begin
      meas_bcd_i <= v;
      meas_valid_i <= 1'b1;
      @(posedge core_clk_i);
      meas_valid_i <= 1'b0;
      @(posedge core_clk_i);
    end
  endtask
  // Hang guard, far above the expected run
  always @(posedge core_clk_i) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      miscompares = miscompares + 1;
      stop_test;
    end
  end
  initial begin
    repeat (2) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    @(posedge core_clk_i);
    cmp("lock rst", 0, lock_o);
    cmp("hold rst", 0, hold_o);
    reg_read(`MRC_REG_CTRL);
    cmp("ctrl rst", 0, rd);
    reg_read(4'hC);
    cmp("unmapped", 0, rd);
    key(8'h31, 1'b0, 1'b1);
    cmd(`MRC_NM_LOCK, 1'b1, 4'h1);
    cmp("lock on", 1, lock_o);
    query(`MRC_NM_LOCKQ, 1'b1);
    cmp("lock query", {"1", CRLF}, host.reply);
    key(8'h32, 1'b0, 1'b0);
    key(8'h33, 1'b1, 1'b1);
    // Unterminated line must not act
    host.send(`MRC_NM_LOCK, 1'b1, 4'h0, 1'b0);
    repeat (20) @(posedge core_clk_i);
    cmp("no term", 1, lock_o);
    host.put(`MRC_CH_CR);
    host.send(48'h0, 1'b0, 4'h0, 1'b1);
    idle;
    cmp("lock off", 0, lock_o);
    key(8'h34, 1'b0, 1'b1);
    reg_write(`MRC_REG_CTRL, 32'h0000_0001);
    cmp("ctrl lock", 1, lock_o);
    reg_write(4'hC, 32'hFFFF_FFFF);
    reg_read(`MRC_REG_CTRL);
    cmp("ctrl read", 1, rd);
    reg_write(`MRC_REG_CTRL, 32'h0000_0000);
    // Peak hold with two digits after the point
    meas_dp_i <= 3'h2;
    meas_mult_i <= 8'h6B;
    cmd(`MRC_NM_HOLD, 1'b1, 4'h1);
    cmp("hold on", 1, hold_o);
    query(`MRC_NM_HOLDQ, 1'b0);
    cmp("hold query", {"1", CRLF}, host.reply);
    cmd(`MRC_NM_CLR, 1'b0, 4'h0);
    meas(20'h0_0123);
    meas(20'h0_0100);
    cmp("peak", 20'h0_0123, peak_bcd_o);
    reg_read(`MRC_REG_PEAK);
    cmp("peak reg", {1'b0, 3'h2, 8'h6B, 20'h0_0123}, rd);
    query(`MRC_NM_VALQ, 1'b1);
    cmp("peak query", {"+001.23", CRLF}, host.reply);
    query(`MRC_NM_MULQ, 1'b0);
    cmp("mult query", {8'h6B, CRLF}, host.reply);
    cmd(`MRC_NM_CLR, 1'b0, 4'h0);
    cmp("peak clear", 0, peak_bcd_o);
    meas(20'h0_0050);
    cmp("peak again", 20'h0_0050, peak_bcd_o);
    cmd(`MRC_NM_HOLD, 1'b1, 4'h0);
    meas(20'h0_0999);
    cmp("hold off", 20'h0_0050, peak_bcd_o);
    query(`MRC_NM_HOLDQ, 1'b0);
    cmp("hold query", {"0", CRLF}, host.reply);
    // Overlong line is dropped whole and flagged
    for (k = 0; k < 16; k = k + 1) host.put(8'h41);
    host.send(48'h0, 1'b0, 4'h0, 1'b1);
    idle;
    reg_read(`MRC_REG_STAT);
    cmp("status ovf", 32'h0000_0022, rd);
    // Every range code, then a probe change
    for (r = 0; r < 4; r = r + 1) begin
      cmd(`MRC_NM_RANGE, 1'b1, r[3:0]);
      cmp("range", {2'h2, r[1:0]}, range_sel_o);
      query(`MRC_NM_RANGEQ, 1'b0);
      cmp("range query", {8'h30 + r[7:0], CRLF}, host.reply);
    end
    reg_write(`MRC_REG_CTRL, 32'h0000_001E);
    reg_read(`MRC_REG_CTRL);
    cmp("ctrl fields", 32'h0000_000E, rd);
    cmp("ctrl clear", 0, peak_bcd_o);
    probe_type_i <= 2'h1;
    repeat (2) @(posedge core_clk_i);
    cmp("probe", {2'h1, 2'h3}, range_sel_o);
    stop_test;
  end
endmodule // meter_remote_command_set_bench
